// >>> core/rgc_cfg.svh
// Constants for the receiver gain configuration register bank
`ifndef RGC_CFG_SVH
`define RGC_CFG_SVH
// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define RGC_IDX_P2P 6'h0b
`define RGC_IDX_FIRST 6'h0d
`define RGC_IDX_SECOND 6'h0e
`define RGC_IDX_CMD 6'h3e
`define RGC_IDX_SPACE 6'h3f
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RGC_RST_P2P 8'h0c
`define RGC_RST_FIRST 8'hd8
`define RGC_RST_SECOND 8'h00
`define RGC_RST_SPACE 1'b0
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RGC_AM1_HI 7
`define RGC_AM1_LO 5
`define RGC_PM1_HI 4
`define RGC_PM1_LO 2
`define RGC_LF_SEL 1
`define RGC_LF_SPLIT 0
`define RGC_AM2_HI 7
`define RGC_AM2_LO 4
`define RGC_PM2_HI 3
`define RGC_PM2_LO 0
`define RGC_OOK_DECAY 7
`define RGC_OOK_TC_HI 6
`define RGC_OOK_TC_LO 5
`define RGC_OOK_THD_HI 4
`define RGC_OOK_THD_LO 3
`define RGC_ASK_TC_HI 2
`define RGC_ASK_TC_LO 1
`define RGC_ASK_THD 0
`define RGC_CMD_GAIN_LOAD 0
`define RGC_SPACE_B 0
`define RGC_REG_LANE 0
// ------------------------------------------------------------
// Decode values, gains in tenths of dB, times in tenths of us
// ------------------------------------------------------------
`define RGC_G1_FULL 3'h0
`define RGC_G1_BOOST 3'h7
`define RGC_G1_STEP 8'h19
`define RGC_G2_MAX 4'ha
`define RGC_G2_WIN_MAX 4'h4
`define RGC_G2_STEP 8'h1e
`define RGC_OOK_TAU0 8'h0e
`define RGC_OOK_TAU1 8'h0a
`define RGC_OOK_TAU2 8'h06
`define RGC_OOK_TAU3 8'h02
`define RGC_ASK_TAU0 8'h54
`define RGC_ASK_TAU1 8'h44
`define RGC_ASK_TAU2 8'h2c
`define RGC_ASK_TAU3 8'h18
`define RGC_OOK_SLOW_THR 32'h19232d37
`define RGC_OOK_FAST_THR 32'h41464b50
`define RGC_ASK_THR_HI 8'h61
`define RGC_ASK_THR_LO 8'h5f
`endif

// >>> core/rgc_pkg.sv
// Types shared by the receiver gain configuration register bank
package rgc_pkg;
  // ----------------------------------------------------------
  // Wishbone carriers
  // ----------------------------------------------------------
  typedef struct packed {
    logic cyc; // Cycle active
    logic stb; // Strobe
    logic we; // Write enable
    logic [7:0] adr; // Byte address
    logic [3:0] sel; // Byte lanes
    logic [31:0] dat; // Write data
  } rgc_wb_req_s;
  typedef struct packed {
    logic ack; // Transfer acknowledge
    logic [31:0] dat; // Read data
  } rgc_wb_rsp_s;
  // ----------------------------------------------------------
  // Front-end controls, index 0 is AM, index 1 is PM
  // ----------------------------------------------------------
  typedef struct packed {
    logic [1:0][7:0] first_atten; // First-stage cut, 0.1 dB
    logic [1:0] first_boost; // First-stage boost active
    logic low_freq_input_select; // LF input signal
    logic low_freq_split_routing; // Split LF inputs
    logic [1:0][7:0] window_atten; // Digitizer widening, 0.1 dB
    logic [1:0][7:0] stage_atten; // Stage 2/3 cut, 0.1 dB
    logic [1:0] second_code_bad; // Code above Ah applied
    logic onoff_fast_decay; // OOK fast decay
    logic [7:0] onoff_time_constant; // 0.1 us units
    logic [7:0] onoff_threshold; // Percent
    logic [7:0] amplitude_key_time_constant; // 0.1 us units
    logic [7:0] amplitude_key_threshold; // Percent
    logic gain_load; // One-cycle load pulse
  } rgc_ctrl_s;
  // ----------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    RGC_BUS_IDLE = 2'b01,
    RGC_BUS_ACK = 2'b10
  } rgc_bus_e;
endpackage : rgc_pkg

// >>> core/rgc_first_gain_dec.sv
// First-stage gain code decoder for one receive channel
`timescale 1ns/1ps
`include "rgc_cfg.svh"
module rgc_first_gain_dec (
  input wire logic [2:0] code_i,
  output logic [7:0] atten_o,
  output logic boost_o
);
  // ----------------------------------------------------------
  // Decode
  // ----------------------------------------------------------
  // Code 0 full gain, 7 boost, middle codes cut per step
  always_comb begin
    atten_o = 8'h00;
    boost_o = 1'b0;
    if (code_i == `RGC_G1_BOOST) begin
      boost_o = 1'b1;
    end else if (code_i != `RGC_G1_FULL) begin
      atten_o = {5'h00, code_i} * `RGC_G1_STEP;
    end
  end
endmodule : rgc_first_gain_dec

// >>> core/rgc_second_gain_dec.sv
// Second-stage and digitizer gain code decoder for one channel
`timescale 1ns/1ps
`include "rgc_cfg.svh"
module rgc_second_gain_dec (
  input wire logic [3:0] code_i,
  output logic [7:0] window_o,
  output logic [7:0] stage_o,
  output logic bad_o
);
  logic [3:0] clamped; // Code limited to the used range
  // ----------------------------------------------------------
  // Decode
  // ----------------------------------------------------------
  // Unused codes act as Ah so the analog side never sees them
  always_comb begin
    bad_o = (code_i > `RGC_G2_MAX);
    clamped = bad_o ? `RGC_G2_MAX : code_i;
    window_o = 8'h00;
    stage_o = 8'h00;
    if (clamped > `RGC_G2_WIN_MAX) begin
      window_o = {4'h0, `RGC_G2_WIN_MAX} * `RGC_G2_STEP;
      stage_o = {4'h0, 4'(clamped - `RGC_G2_WIN_MAX)} * `RGC_G2_STEP;
    end else begin
      window_o = {4'h0, clamped} * `RGC_G2_STEP;
    end
  end
endmodule : rgc_second_gain_dec

// >>> core/rgc_regs.sv
// Receiver gain configuration registers behind a Wishbone slave
// What this block does
// - AM first gain: full, 2.5 dB cuts, boost
// - PM first gain uses the same encoding
// - Input select bit: HF clear, LF set
// - LF routing: differential or split per channel
// - AM second code 0h-Ah, 3 dB steps
// - PM second code follows the AM encoding
// - Second gain applies only on load command
// - OOK time constant 1.4 to 0.2 us
// - ASK time constant 8.4 to 2.4 us
// - OOK threshold depends on OOK time code
// - Gains in space A, P2P in B
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "rgc_cfg.svh"
module rgc_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire rgc_pkg::rgc_wb_req_s wb_req_i,
  output rgc_pkg::rgc_wb_rsp_s wb_rsp_o,
  output rgc_pkg::rgc_ctrl_s ctrl_o
);
  // ----------------------------------------------------------
  // Storage
  // ----------------------------------------------------------
  logic space_b; // Register space B selected
  logic [7:0] p2p_receiver_config; // Space B register
  logic [7:0] receiver_first_stage_gain; // Space A register
  logic [7:0] receiver_second_stage_gain; // Space A register
  logic [7:0] second_applied; // Copy seen by gain loops
  logic gain_load; // Load pulse toward gain loops
  rgc_pkg::rgc_bus_e state; // Bus slave state
  logic ack; // Registered acknowledge
  logic [31:0] rdata; // Registered read data
  // ----------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------
  logic req; // Request present
  logic [5:0] idx; // Word index of the access
  logic commit; // Write takes effect this edge
  logic lane_ok; // Data lane of the registers enabled
  logic [31:0] next_rdata; // Read data for the current index
  logic [1:0] ook_tc_code; // OOK time code
  logic [1:0] ook_thd; // OOK threshold code
  logic [1:0] ask_tc_code; // ASK time code
  logic [31:0] ook_table; // Threshold row in use
  logic [7:0] next_ook_tau; // OOK time constant
  logic [7:0] next_ask_tau; // ASK time constant
  logic [7:0] next_ook_thr; // OOK threshold
  logic [1:0][2:0] first_code; // Per-channel first codes
  logic [1:0][3:0] second_code; // Per-channel second codes
  logic [1:0][7:0] first_atten; // Decoder outputs
  logic [1:0] first_boost; // Decoder outputs
  logic [1:0][7:0] window_atten; // Decoder outputs
  logic [1:0][7:0] stage_atten; // Decoder outputs
  logic [1:0] second_bad; // Decoder outputs
  assign req = wb_req_i.cyc & wb_req_i.stb;
  assign idx = wb_req_i.adr[7:2];
  assign lane_ok = wb_req_i.sel[`RGC_REG_LANE];
  // Write lands on the edge where the master sees ack high
  assign commit = req & wb_req_i.we & lane_ok &
    (state == rgc_pkg::RGC_BUS_ACK);
  // ----------------------------------------------------------
  // Bus slave handshake
  // ----------------------------------------------------------
  // One wait state, then ack for one cycle, then idle again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= rgc_pkg::RGC_BUS_IDLE;
      ack <= 1'b0;
    end else begin
      case (state)
        rgc_pkg::RGC_BUS_IDLE: begin
          if (req) begin
            state <= rgc_pkg::RGC_BUS_ACK;
            ack <= 1'b1;
          end
        end
        rgc_pkg::RGC_BUS_ACK: begin
          // Forced idle cycle keeps a held request from acking twice
          state <= rgc_pkg::RGC_BUS_IDLE;
          ack <= 1'b0;
        end
        default: begin
          state <= rgc_pkg::RGC_BUS_IDLE;
          ack <= 1'b0;
        end
      endcase
    end
  end
  // ----------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------
  // Space-dependent map; unmapped indices read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (idx)
      `RGC_IDX_SPACE: begin
        next_rdata[`RGC_SPACE_B] = space_b;
      end
      `RGC_IDX_FIRST: begin
        if (!space_b) begin
          next_rdata[7:0] = receiver_first_stage_gain;
        end
      end
      `RGC_IDX_SECOND: begin
        if (!space_b) begin
          next_rdata[7:0] = receiver_second_stage_gain;
        end
      end
      `RGC_IDX_P2P: begin
        if (space_b) begin
          next_rdata[7:0] = p2p_receiver_config;
        end
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end
  // Read data captured with the ack, held low otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata <= 32'h0000_0000;
    end else if (state == rgc_pkg::RGC_BUS_IDLE && req) begin
      rdata <= wb_req_i.we ? 32'h0000_0000 : next_rdata;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
  // ----------------------------------------------------------
  // Space select
  // ----------------------------------------------------------
  // Visible at the same index in both spaces so it is never lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      space_b <= `RGC_RST_SPACE;
    end else if (commit && idx == `RGC_IDX_SPACE) begin
      space_b <= wb_req_i.dat[`RGC_SPACE_B];
    end
  end
  // ----------------------------------------------------------
  // Space A gain registers
  // ----------------------------------------------------------
  // Writes only land when space A is selected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receiver_first_stage_gain <= `RGC_RST_FIRST;
      receiver_second_stage_gain <= `RGC_RST_SECOND;
    end else if (commit && !space_b) begin
      if (idx == `RGC_IDX_FIRST) begin
        receiver_first_stage_gain <= wb_req_i.dat[7:0];
      end
      if (idx == `RGC_IDX_SECOND) begin
        receiver_second_stage_gain <= wb_req_i.dat[7:0];
      end
    end
  end
  // ----------------------------------------------------------
  // Space B peer-to-peer register
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p2p_receiver_config <= `RGC_RST_P2P;
    end else if (commit && space_b && idx == `RGC_IDX_P2P) begin
      p2p_receiver_config <= wb_req_i.dat[7:0];
    end
  end
  // ----------------------------------------------------------
  // Gain load command
  // ----------------------------------------------------------
  // Gain loops keep the old code until software asks for a load;
  // a write to the register alone changes nothing downstream
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_applied <= `RGC_RST_SECOND;
      gain_load <= 1'b0;
    end else if (commit && idx == `RGC_IDX_CMD &&
                 wb_req_i.dat[`RGC_CMD_GAIN_LOAD]) begin
      second_applied <= receiver_second_stage_gain;
      gain_load <= 1'b1;
    end else begin
      gain_load <= 1'b0;
    end
  end
  // ----------------------------------------------------------
  // Per-channel gain decoders
  // ----------------------------------------------------------
  assign first_code[0] =
    receiver_first_stage_gain[`RGC_AM1_HI:`RGC_AM1_LO];
  assign first_code[1] =
    receiver_first_stage_gain[`RGC_PM1_HI:`RGC_PM1_LO];
  assign second_code[0] =
    second_applied[`RGC_AM2_HI:`RGC_AM2_LO];
  assign second_code[1] =
    second_applied[`RGC_PM2_HI:`RGC_PM2_LO];
  // Same decoders for AM and PM keep the two encodings identical
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    rgc_first_gain_dec u_first (
      .code_i(first_code[ch]),
      .atten_o(first_atten[ch]),
      .boost_o(first_boost[ch])
    );
    rgc_second_gain_dec u_second (
      .code_i(second_code[ch]),
      .window_o(window_atten[ch]),
      .stage_o(stage_atten[ch]),
      .bad_o(second_bad[ch])
    );
  end
  // ----------------------------------------------------------
  // Demodulator decode
  // ----------------------------------------------------------
  assign ook_tc_code =
    p2p_receiver_config[`RGC_OOK_TC_HI:`RGC_OOK_TC_LO];
  assign ook_thd =
    p2p_receiver_config[`RGC_OOK_THD_HI:`RGC_OOK_THD_LO];
  assign ask_tc_code =
    p2p_receiver_config[`RGC_ASK_TC_HI:`RGC_ASK_TC_LO];
  // Time constants and thresholds as numbers for the analog side
  always_comb begin
    case (ook_tc_code)
      2'h0: next_ook_tau = `RGC_OOK_TAU0;
      2'h1: next_ook_tau = `RGC_OOK_TAU1;
      2'h2: next_ook_tau = `RGC_OOK_TAU2;
      default: next_ook_tau = `RGC_OOK_TAU3;
    endcase
    case (ask_tc_code)
      2'h0: next_ask_tau = `RGC_ASK_TAU0;
      2'h1: next_ask_tau = `RGC_ASK_TAU1;
      2'h2: next_ask_tau = `RGC_ASK_TAU2;
      default: next_ask_tau = `RGC_ASK_TAU3;
    endcase
    // Slow time code picks the low threshold row
    ook_table = (ook_tc_code == 2'h0) ? `RGC_OOK_SLOW_THR
                                 : `RGC_OOK_FAST_THR;
    next_ook_thr = ook_table[{ook_thd, 3'h0} +: 8];
  end
  // ----------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------
  // Decoded values lag their register by one clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o.first_atten <= first_atten;
      ctrl_o.first_boost <= first_boost;
      ctrl_o.low_freq_input_select <=
        receiver_first_stage_gain[`RGC_LF_SEL];
      ctrl_o.low_freq_split_routing <=
        receiver_first_stage_gain[`RGC_LF_SPLIT];
      ctrl_o.window_atten <= window_atten;
      ctrl_o.stage_atten <= stage_atten;
      ctrl_o.second_code_bad <= second_bad;
      ctrl_o.onoff_fast_decay <=
        p2p_receiver_config[`RGC_OOK_DECAY];
      ctrl_o.onoff_time_constant <= next_ook_tau;
      ctrl_o.onoff_threshold <= next_ook_thr;
      ctrl_o.amplitude_key_time_constant <= next_ask_tau;
      ctrl_o.amplitude_key_threshold <=
        p2p_receiver_config[`RGC_ASK_THD] ? `RGC_ASK_THR_LO
                                          : `RGC_ASK_THR_HI;
      ctrl_o.gain_load <= gain_load;
    end
  end
  // Bus answer straight from flip-flops
  assign wb_rsp_o = '{ack: ack, dat: rdata};
endmodule : rgc_regs

// >>> tb/rgc_regs_checker.sv
// Assertion checker bound to the receiver gain register bank
`timescale 1ns/1ps
module rgc_regs_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire rgc_pkg::rgc_wb_req_s wb_req_i,
  input wire rgc_pkg::rgc_wb_rsp_s wb_rsp_o,
  input wire rgc_pkg::rgc_ctrl_s ctrl_o
);
  // ----------------------------------------------------------
  // Clocking and helpers
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic cmd_hit; // Load command committing at this edge
  assign cmd_hit = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we &&
    wb_rsp_o.ack && wb_req_i.adr == 8'hf8 && wb_req_i.sel[0] &&
    wb_req_i.dat[0];
  // ----------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------
  property p_ack_pulse; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");
  property p_ack_cause;
    wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  property p_dat_idle; !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data not zero outside ack");
  // ----------------------------------------------------------
  // Decoded gain fields; the past-reset guard skips the edge
  // where outputs still show the zeros forced during reset
  // ----------------------------------------------------------
  property p_first_am;
    !$past(rst_i) |-> (ctrl_o.first_boost[0] ? ctrl_o.first_atten[0] == 8'h0
      : ctrl_o.first_atten[0] inside {8'h0, 8'h19, 8'h32, 8'h4b, 8'h64,
      8'h7d, 8'h96});
  endproperty
  a_first_am: assert property (p_first_am)
    else $error("AM first stage decode out of range");
  property p_first_pm;
    !$past(rst_i) |-> (ctrl_o.first_boost[1] ? ctrl_o.first_atten[1] == 8'h0
      : ctrl_o.first_atten[1] inside {8'h0, 8'h19, 8'h32, 8'h4b, 8'h64,
      8'h7d, 8'h96});
  endproperty
  a_first_pm: assert property (p_first_pm)
    else $error("PM first stage decode out of range");
  property p_second_am;
    ctrl_o.window_atten[0] <= 8'h78 && (ctrl_o.stage_atten[0] == 8'h0 ||
      ctrl_o.window_atten[0] == 8'h78);
  endproperty
  a_second_am: assert property (p_second_am)
    else $error("AM stage cut before window is full");
  property p_second_pm;
    ctrl_o.window_atten[1] <= 8'h78 && (ctrl_o.stage_atten[1] == 8'h0 ||
      ctrl_o.window_atten[1] == 8'h78);
  endproperty
  a_second_pm: assert property (p_second_pm)
    else $error("PM stage cut before window is full");
  // ----------------------------------------------------------
  // Second stage values move only with the load pulse
  // ----------------------------------------------------------
  property p_second_hold;
    $changed(ctrl_o.window_atten) || $changed(ctrl_o.stage_atten)
      |-> ctrl_o.gain_load;
  endproperty
  a_second_hold: assert property (p_second_hold)
    else $error("second stage changed without load");
  property p_load; cmd_hit |-> ##[1:3] ctrl_o.gain_load; endproperty
  a_load: assert property (p_load)
    else $error("load command gave no load pulse");
  // ----------------------------------------------------------
  // Peer-to-peer demodulator fields
  // ----------------------------------------------------------
  property p_ook_tau;
    !$past(rst_i) |-> ctrl_o.onoff_time_constant inside {8'h0e, 8'h0a,
      8'h06, 8'h02};
  endproperty
  a_ook_tau: assert property (p_ook_tau)
    else $error("OOK time constant out of range");
  property p_ook_thr;
    !$past(rst_i) |-> ((ctrl_o.onoff_time_constant == 8'h0e) ?
      ctrl_o.onoff_threshold inside {8'h37, 8'h2d, 8'h23, 8'h19} :
      ctrl_o.onoff_threshold inside {8'h50, 8'h4b, 8'h46, 8'h41});
  endproperty
  a_ook_thr: assert property (p_ook_thr)
    else $error("OOK threshold does not match time constant");
  property p_ask;
    !$past(rst_i) |-> ctrl_o.amplitude_key_time_constant inside {8'h54,
      8'h44, 8'h2c, 8'h18} && ctrl_o.amplitude_key_threshold inside
      {8'h61, 8'h5f};
  endproperty
  a_ask: assert property (p_ask)
    else $error("ASK decode out of range");
  // Main scenarios reached
  c_load: cover property (ctrl_o.gain_load);
  c_boost: cover property (ctrl_o.first_boost[0]);
  c_bad: cover property (ctrl_o.second_code_bad[1]);
endmodule : rgc_regs_checker

bind rgc_regs rgc_regs_checker u_checker (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .ctrl_o(ctrl_o));

// >>> tb/tb.sv
// Self-checking testbench for the receiver gain register bank
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------
  // Signals and expected-value tables
  // ----------------------------------------------------------
  logic clk_i = 1'b0; // 25 MHz clock
  logic rst_i = 1'b1; // Synchronous reset
  rgc_pkg::rgc_wb_req_s wb_req_i = '0; // Bus request
  rgc_pkg::rgc_wb_rsp_s wb_rsp_o; // Bus answer
  rgc_pkg::rgc_ctrl_s ctrl_o; // Decoded controls
  int num_errors = 0; // Mismatches
  int n_tests = 0; // Comparisons
  logic [31:0] rd; // Last read data
  logic [2:0] am, pm; // First stage codes
  logic [3:0] am2, pm2, am_prev, lv; // Second stage codes, loop value
  logic [7:0] v; // P2P register image
  logic [7:0] ook_tau [4] = '{8'h0e, 8'h0a, 8'h06, 8'h02};
  logic [7:0] ask_tau [4] = '{8'h54, 8'h44, 8'h2c, 8'h18};
  logic [7:0] thr_slow [4] = '{8'h37, 8'h2d, 8'h23, 8'h19};
  logic [7:0] thr_fast [4] = '{8'h50, 8'h4b, 8'h46, 8'h41};
  always #20 clk_i = ~clk_i;
  rgc_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .ctrl_o(ctrl_o));
  // ----------------------------------------------------------
  // Expected decodes
  // ----------------------------------------------------------
  function automatic logic [31:0] g1(input logic [2:0] c);
    return (c == 3'h0 || c == 3'h7) ? 32'h0 : 32'(c) * 32'h19;
  endfunction : g1
  // Codes above Ah act as Ah
  function automatic logic [31:0] clamp(input logic [3:0] c);
    return (c > 4'ha) ? 32'ha : 32'(c);
  endfunction : clamp
  function automatic logic [31:0] win(input logic [3:0] c);
    return ((clamp(c) < 32'h4) ? clamp(c) : 32'h4) * 32'h1e;
  endfunction : win
  function automatic logic [31:0] stg(input logic [3:0] c);
    return (clamp(c) > 32'h4) ? (clamp(c) - 32'h4) * 32'h1e : 32'h0;
  endfunction : stg
  // ----------------------------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One classic cycle; request held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] adr,
    input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel,
      dat: dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp_o.ack !== 1'b1 && n < 20);
    check("ack", 32'(wb_rsp_o.ack), 32'h1);
    rd = wb_rsp_o.dat;
    wb_req_i <= '0;
  endtask : xfer
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat, 4'h1);
    repeat (2) @(posedge clk_i); // Let outputs follow the commit
  endtask : wr
  task automatic chk_rd(input string name, input logic [7:0] adr,
    input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0, 4'hf);
    check(name, rd, exp);
  endtask : chk_rd
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------
  // Watchdog; the sequence needs about four hundred cycles
  // ----------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end
  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    am_prev = 4'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Defaults after reset
    chk_rd("first_rst", 8'h34, 32'hd8);
    chk_rd("second_rst", 8'h38, 32'h0);
    check("am1_rst", 32'(ctrl_o.first_atten[0]), 32'h96);
    check("pm1_rst", 32'(ctrl_o.first_atten[1]), 32'h96);
    // First stage codes, every one on both channels
    for (int c = 0; c < 8; c++) begin
      am = 3'(c);
      pm = 3'(7 - c);
      wr(8'h34, {24'h0, am, pm, am[0], pm[0]});
      check("am1", 32'(ctrl_o.first_atten[0]), g1(am));
      check("am_bst", 32'(ctrl_o.first_boost[0]), 32'(am == 3'h7));
      check("pm1", 32'(ctrl_o.first_atten[1]), g1(pm));
      check("pm_bst", 32'(ctrl_o.first_boost[1]), 32'(pm == 3'h7));
      check("lf_sel", 32'(ctrl_o.low_freq_input_select), 32'(am[0]));
      check("lf_spl", 32'(ctrl_o.low_freq_split_routing), 32'(pm[0]));
      chk_rd("first_rd", 8'h34, {24'h0, am, pm, am[0], pm[0]});
    end
    // Second stage codes 0h to Bh, held until the load command
    for (int i = 0; i < 12; i++) begin
      am2 = 4'(i);
      pm2 = 4'(11 - i);
      wr(8'h38, {24'h0, am2, pm2});
      check("am_hold", 32'(ctrl_o.window_atten[0]), win(am_prev));
      wr(8'hf8, 32'h1);
      check("am_win", 32'(ctrl_o.window_atten[0]), win(am2));
      check("am_stg", 32'(ctrl_o.stage_atten[0]), stg(am2));
      check("am_bad", 32'(ctrl_o.second_code_bad[0]), 32'(am2 > 4'ha));
      check("pm_win", 32'(ctrl_o.window_atten[1]), win(pm2));
      check("pm_stg", 32'(ctrl_o.stage_atten[1]), stg(pm2));
      check("pm_bad", 32'(ctrl_o.second_code_bad[1]), 32'(pm2 > 4'ha));
      chk_rd("second_rd", 8'h38, {24'h0, am2, pm2});
      am_prev = am2;
    end
    // Peer-to-peer register lives in space B only
    wr(8'hfc, 32'h1);
    chk_rd("space_rd", 8'hfc, 32'h1);
    chk_rd("p2p_rst", 8'h2c, 32'h0c);
    chk_rd("a_hidden", 8'h34, 32'h0);
    for (int i = 0; i < 16; i++) begin
      lv = 4'(i);
      v = {lv[3], lv[3:2], lv[1:0], lv[1:0], lv[2]};
      wr(8'h2c, {24'h0, v});
      check("fd", 32'(ctrl_o.onoff_fast_decay), 32'(lv[3]));
      check("ook_tau", 32'(ctrl_o.onoff_time_constant),
        32'(ook_tau[lv[3:2]]));
      check("ook_thr", 32'(ctrl_o.onoff_threshold), 32'((lv[3:2] == 2'h0) ?
        thr_slow[lv[1:0]] : thr_fast[lv[1:0]]));
      check("ask_tau", 32'(ctrl_o.amplitude_key_time_constant),
        32'(ask_tau[lv[1:0]]));
      check("ask_thr", 32'(ctrl_o.amplitude_key_threshold),
        lv[2] ? 32'h5f : 32'h61);
      chk_rd("p2p_rd", 8'h2c, {24'h0, v});
    end
    // Space A write ignored while space B is selected
    wr(8'h34, 32'h0);
    wr(8'hfc, 32'h0);
    chk_rd("a_kept", 8'h34, 32'he2);
    chk_rd("b_hidden", 8'h2c, 32'h0);
    // Refusals: lane off, unmapped place, command readback
    xfer(1'b1, 8'h34, 32'h0, 4'h0);
    chk_rd("sel_off", 8'h34, 32'he2);
    chk_rd("unmapped", 8'h00, 32'h0);
    chk_rd("cmd_rd", 8'hf8, 32'h0);
    // Reset in mid-run restores the defaults
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_rd("first_rst2", 8'h34, 32'hd8);
    wrap_up();
  end
endmodule : tb
